// ---- dv/host_pin_model.sv ----
// Purpose: Host side of chip select and the reset pin.
// Assumes: Supply level arrives as a digital flag.
// Notes: Reset pin held low while supply is short, as extra guard.
`timescale 1ns/1ns
module host_pin_model #(
	parameter int SEL_WAIT = 20
) (
	input wire logic clk,
	input wire logic vmin,
	input wire logic sel_req,
	input wire logic rst_req,
	output logic select_n,
	output logic reset_n
);
	int cnt = 0;
	always @(posedge clk) cnt <= vmin ? (cnt < SEL_WAIT ? cnt + 1 : cnt) : 0;
	assign select_n = !(sel_req && cnt >= SEL_WAIT);
	assign reset_n = !(rst_req || !vmin);
endmodule

// ---- dv/seq_monitor.sv ----
// Purpose: Port assertions for the power and reset sequencer.
// Assumes: Pins pass a two-stage sync before use.
// Notes: Delay windows leave slack for that sync.
`timescale 1ns/1ns
module seq_monitor (
	input wire logic CLK,
	input wire logic RST,
	input wire logic ABOVE_INHIBIT,
	input wire logic RESET_N,
	input wire logic WRITE_CMD_SEEN,
	input wire logic CORE_RESET,
	input wire logic SELECT_ALLOWED,
	input wire logic READ_ALLOWED,
	input wire logic WRITE_ALLOWED,
	input wire logic WRITE_ACCEPT,
	input wire logic READ_ACCEPT,
	input wire logic WRITE_ENABLE_LATCH,
	input wire logic CYCLE_ACTIVE_FLAG,
	input wire logic WRITE_LOCK,
	input wire logic LOCK_DOWN,
	input wire logic DEEP_SLEEP,
	input wire logic [7:0] ERASED_VALUE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	chk_low_supply_hold: assert property (!ABOVE_INHIBIT [*4] |-> CORE_RESET)
		else $error("core not held with supply low");
	chk_write_gate: assert property (WRITE_ACCEPT |-> $past(WRITE_ALLOWED))
		else $error("write accepted during holdoff");
	chk_refused_write: assert property (WRITE_CMD_SEEN && !WRITE_ALLOWED |=> !WRITE_ACCEPT)
		else $error("refused write was accepted");
	chk_read_gate: assert property (READ_ACCEPT |-> $past(READ_ALLOWED))
		else $error("read accepted too early");
	chk_reset_state: assert property (CORE_RESET |->
		!(WRITE_ENABLE_LATCH | CYCLE_ACTIVE_FLAG | WRITE_LOCK | LOCK_DOWN | DEEP_SLEEP))
		else $error("state bits set while held");
	chk_reset_gates: assert property (CORE_RESET |-> !SELECT_ALLOWED && !WRITE_ALLOWED)
		else $error("access allowed while held");
	chk_pin_locks: assert property ($fell(RESET_N) |-> ##[1:4] !(WRITE_LOCK | LOCK_DOWN))
		else $error("locks kept after reset pin");
	chk_refuse_select: assert property ($fell(RESET_N) && !CYCLE_ACTIVE_FLAG |-> ##4 !SELECT_ALLOWED)
		else $error("select allowed in reset mode");
	chk_erased_ones: assert property (ERASED_VALUE == 8'hFF)
		else $error("erased value not all ones");
endmodule
bind flash_power_reset_sequencer seq_monitor mon (.*);

// ---- dv/tb_flash_power_reset_sequencer.sv ----
// Purpose: Directed checks of supply, holdoff and reset-pin sequencing.
// Assumes: Small counts: holdoff 50, select 20, status 10.
// Notes: Pulse outputs are caught in a sticky vector.
`timescale 1ns/1ns
module tb_flash_power_reset_sequencer;
	logic clk = 0, rst = 1, inh = 0, vmin = 0, dec = 0, sel_req = 0, rst_req = 0;
	logic [6:0] p = 0;
	logic [3:0] seen = 0;
	int err_count = 0, tests_run = 0, cyc = 0;
	wire sel_n, res_n;
	logic core_rst, sel_ok, rd_ok, wr_ok, wr_acc, rd_acc, abort, discard, write_enable_latch, cycle_active_flag, wlock, ldown, deep;
	logic [7:0] erased;
	always #5 clk = ~clk;
	host_pin_model #(.SEL_WAIT(20)) host (.clk(clk), .vmin(vmin), .sel_req(sel_req), .rst_req(rst_req),
		.select_n(sel_n), .reset_n(res_n));
	flash_power_reset_sequencer #(.HOLDOFF_CYC(50), .SELECT_CYC(20), .STATUS_CYC(10)) uut (
		.CLK(clk), .RST(rst), .ABOVE_INHIBIT(inh), .ABOVE_MIN(vmin), .RESET_N(res_n), .SELECT_N(sel_n),
		.DECODE_ACTIVE(dec), .WRITE_CMD_SEEN(p[0]), .READ_CMD_SEEN(p[1]), .ARRAY_CYCLE_START(p[2]),
		.STATUS_CYCLE_START(p[3]), .CYCLE_DONE(p[4]), .LOCK_SET(p[5]), .ENTER_DEEP_SLEEP(p[6]),
		.CORE_RESET(core_rst), .SELECT_ALLOWED(sel_ok), .READ_ALLOWED(rd_ok), .WRITE_ALLOWED(wr_ok),
		.WRITE_ACCEPT(wr_acc), .READ_ACCEPT(rd_acc), .ABORT_CYCLE(abort), .DISCARD_CMD(discard),
		.WRITE_ENABLE_LATCH(write_enable_latch), .CYCLE_ACTIVE_FLAG(cycle_active_flag), .WRITE_LOCK(wlock), .LOCK_DOWN(ldown),
		.DEEP_SLEEP(deep), .ERASED_VALUE(erased));
	always @(posedge clk) seen <= seen | {abort, discard, wr_acc, rd_acc};
	task automatic wrap_up();
		if (err_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// The ceiling is about five times the directed run length.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 1200) begin
			err_count++;
			wrap_up();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic fire(input logic [6:0] v);
		@(negedge clk) p = v;
		@(negedge clk) p = 0;
		wait_n(1);
	endtask
	task automatic pin(input int n);
		@(negedge clk) rst_req = 1;
		wait_n(n);
		rst_req = 0;
	endtask
	initial begin
		wait_n(16);
		rst = 0;
		wait_n(4);
		chk(core_rst, 1);
		chk(erased, 8'hFF);
		fire(7'h03);
		chk(seen, 0);
		inh = 1;
		vmin = 1;
		wait_n(35);
		chk({core_rst, deep, write_enable_latch, cycle_active_flag, wlock, ldown}, 0);
		chk({sel_ok, rd_ok, wr_ok}, 6);
		seen = 0;
		fire(7'h03);
		chk({write_enable_latch, seen}, 1);
		wait_n(30);
		chk(wr_ok, 1);
		seen = 0;
		fire(7'h01);
		chk(seen, 2);
		fire(7'h60);
		chk({deep, wlock, ldown}, 7);
		pin(3);
		wait_n(2);
		chk({core_rst, deep, wlock, ldown}, 8);
		chk(sel_ok, 0);
		wait_n(20);
		chk(core_rst, 0);
		fire(7'h04);
		chk(cycle_active_flag, 1);
		seen = 0;
		pin(3);
		wait_n(3);
		chk(seen[3], 1);
		wait_n(20);
		chk(cycle_active_flag, 0);
		sel_req = 1;
		dec = 1;
		seen = 0;
		pin(3);
		wait_n(3);
		chk(seen[2], 1);
		dec = 0;
		sel_req = 0;
		wait_n(20);
		seen = 0;
		fire(7'h08);
		chk(cycle_active_flag, 1);
		fire(7'h10);
		chk({cycle_active_flag, core_rst}, 0);
		fire(7'h08);
		@(negedge clk) rst_req = 1;
		wait_n(4);
		chk({core_rst, cycle_active_flag}, 1);
		wait_n(12);
		rst_req = 0;
		chk({core_rst, seen[3]}, 2);
		wait_n(20);
		inh = 0;
		vmin = 0;
		wait_n(6);
		chk(core_rst, 1);
		wrap_up();
	end
endmodule

// ---- hdl/flash_power_reset_sequencer.sv ----
// Purpose: Supply, holdoff and reset-pin sequencing for a serial flash core.
// Assumes: Supply comparators arrive as digital levels; pins are asynchronous.
// Notes: Decoding and array cycles live elsewhere and report over plain ports.
// Function
// - Below write-inhibit threshold, hold logic in reset and ignore all instructions.
// - Ignore write-type instructions until write holdoff delay elapsed after threshold.
// - Accept reads once select delay passed, even if holdoff still running.
// - Power-up gives standby, clear enable latch, active flag and lock bits.
// - Reset low during array cycle aborts that cycle; data may be lost.
// - Any reset low pulse clears every lock bit to zero.
// - Reset while decoding with select low returns power-on state, drops instruction.
// - Reset during program or erase cycle returns power-on state.
// - Reset during status write lets it finish, then power-on state.
// - Reset while deselected in standby returns power-on state, data untouched.
// - Delivered array reads all ones, usable status bits read zero.
// - Reset low enters reset mode, refuses selection until recovery time passes.
`timescale 1ns/1ns
module flash_power_reset_sequencer
	import pwr_seq_pkg::*;
#(
	parameter int HOLDOFF_CYC = WRITE_HOLDOFF_CYC,
	parameter int SELECT_CYC = SELECT_AFTER_SUPPLY_CYC,
	parameter int STATUS_CYC = STATUS_WRITE_CYC
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic ABOVE_INHIBIT,
	input wire logic ABOVE_MIN,
	input wire logic RESET_N,
	input wire logic SELECT_N,
	input wire logic DECODE_ACTIVE,
	input wire logic WRITE_CMD_SEEN,
	input wire logic READ_CMD_SEEN,
	input wire logic ARRAY_CYCLE_START,
	input wire logic STATUS_CYCLE_START,
	input wire logic CYCLE_DONE,
	input wire logic LOCK_SET,
	input wire logic ENTER_DEEP_SLEEP,
	output logic CORE_RESET,
	output logic SELECT_ALLOWED,
	output logic READ_ALLOWED,
	output logic WRITE_ALLOWED,
	output logic WRITE_ACCEPT,
	output logic READ_ACCEPT,
	output logic ABORT_CYCLE,
	output logic DISCARD_CMD,
	output logic WRITE_ENABLE_LATCH,
	output logic CYCLE_ACTIVE_FLAG,
	output logic WRITE_LOCK,
	output logic LOCK_DOWN,
	output logic DEEP_SLEEP,
	output logic [7:0] ERASED_VALUE
);
	logic [1:0] inh_sync;
	logic [1:0] min_sync;
	logic [1:0] rst_sync;
	logic [1:0] sel_sync;
	logic above_inh;
	logic above_min;
	logic pin_low;
	logic selected;
	logic rst_prev;
	logic rst_fall;
	logic [CNT_W-1:0] hold_cnt;
	logic [CNT_W-1:0] sel_cnt;
	logic [CNT_W-1:0] rec_cnt;
	logic [CNT_W-1:0] stw_cnt;
	logic hold_done;
	logic sel_done;
	logic power_on;
	seq_state_t state;
	seq_state_t next_state;

	function automatic logic [CNT_W-1:0] count_up(input logic [CNT_W-1:0] c, input int lim);
		count_up = (c < CNT_W'(lim)) ? c + CNT_W'(1) : c;
	endfunction

	// Pins come from outside the clock domain; second stage only is read.
	always_ff @(posedge CLK) begin
		if (RST) begin
			inh_sync <= 2'h0;
			min_sync <= 2'h0;
			rst_sync <= 2'h3;
			sel_sync <= 2'h3;
		end else begin
			inh_sync <= {inh_sync[0], ABOVE_INHIBIT};
			min_sync <= {min_sync[0], ABOVE_MIN};
			rst_sync <= {rst_sync[0], RESET_N};
			sel_sync <= {sel_sync[0], SELECT_N};
		end
	end
	assign above_inh = inh_sync[1];
	assign above_min = min_sync[1];
	assign pin_low = ~rst_sync[1];
	assign selected = ~sel_sync[1];

	always_ff @(posedge CLK) begin
		if (RST) begin
			rst_prev <= 1'h0;
		end else begin
			rst_prev <= pin_low;
		end
	end
	assign rst_fall = pin_low & ~rst_prev;

	always_ff @(posedge CLK) begin
		if (RST || !above_inh) begin
			hold_cnt <= '0;
		end else begin
			hold_cnt <= count_up(hold_cnt, HOLDOFF_CYC);
		end
	end
	always_ff @(posedge CLK) begin
		if (RST || !above_min || !above_inh) begin
			sel_cnt <= '0;
		end else begin
			sel_cnt <= count_up(sel_cnt, SELECT_CYC);
		end
	end
	assign hold_done = hold_cnt >= CNT_W'(HOLDOFF_CYC);
	assign sel_done = sel_cnt >= CNT_W'(SELECT_CYC);

	// recovery counter restarts while pin low
	always_ff @(posedge CLK) begin
		if (RST || pin_low) begin
			rec_cnt <= '0;
		end else begin
			rec_cnt <= count_up(rec_cnt, POST_RESET_RECOVERY_CYC);
		end
	end

	// status write time runs out even across a reset pulse
	always_ff @(posedge CLK) begin
		if (RST || (state != ST_STATUS_CYCLE && state != ST_STATUS_FINISH)) begin
			stw_cnt <= '0;
		end else begin
			stw_cnt <= count_up(stw_cnt, STATUS_CYC);
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			ST_OFF: begin
				if (above_inh) begin
					next_state = ST_STANDBY;
				end
			end
			ST_STANDBY, ST_DECODE: begin
				if (pin_low) begin
					next_state = ST_RESET_HOLD;
				end else if (ARRAY_CYCLE_START) begin
					next_state = ST_ARRAY_CYCLE;
				end else if (STATUS_CYCLE_START) begin
					next_state = ST_STATUS_CYCLE;
				end else begin
					next_state = (selected && DECODE_ACTIVE) ? ST_DECODE : ST_STANDBY;
				end
			end
			ST_ARRAY_CYCLE: begin
				if (pin_low) begin
					next_state = ST_RESET_HOLD;
				end else if (CYCLE_DONE) begin
					next_state = ST_STANDBY;
				end
			end
			ST_STATUS_CYCLE: begin
				if (pin_low) begin
					next_state = ST_STATUS_FINISH;
				end else if (CYCLE_DONE) begin
					next_state = ST_STANDBY;
				end
			end
			ST_STATUS_FINISH: begin
				if (stw_cnt >= CNT_W'(STATUS_CYC)) begin
					next_state = ST_RESET_HOLD;
				end
			end
			ST_RESET_HOLD: begin
				if (!pin_low && rec_cnt >= CNT_W'(POST_RESET_RECOVERY_CYC)) begin
					next_state = ST_STANDBY;
				end
			end
			default: next_state = ST_OFF;
		endcase
		if (!above_inh) begin
			next_state = ST_OFF;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			state <= ST_OFF;
		end else begin
			state <= next_state;
		end
	end
	assign power_on = (next_state == ST_OFF) || (next_state == ST_RESET_HOLD);

	// reads need only the select delay
	always_ff @(posedge CLK) begin
		if (RST) begin
			CORE_RESET <= 1'h1;
			SELECT_ALLOWED <= 1'h0;
			READ_ALLOWED <= 1'h0;
			WRITE_ALLOWED <= 1'h0;
		end else begin
			CORE_RESET <= next_state == ST_OFF || next_state == ST_RESET_HOLD;
			SELECT_ALLOWED <= sel_done && (next_state == ST_STANDBY || next_state == ST_DECODE);
			READ_ALLOWED <= sel_done && (next_state == ST_STANDBY || next_state == ST_DECODE);
			WRITE_ALLOWED <= sel_done && hold_done && (next_state == ST_STANDBY || next_state == ST_DECODE);
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			WRITE_ACCEPT <= 1'h0;
			READ_ACCEPT <= 1'h0;
			ABORT_CYCLE <= 1'h0;
			DISCARD_CMD <= 1'h0;
		end else begin
			WRITE_ACCEPT <= WRITE_CMD_SEEN && WRITE_ALLOWED && !DEEP_SLEEP && !pin_low;
			READ_ACCEPT <= READ_CMD_SEEN && READ_ALLOWED && !DEEP_SLEEP && !pin_low;
			ABORT_CYCLE <= state == ST_ARRAY_CYCLE && (pin_low || !above_inh);
			DISCARD_CMD <= state == ST_DECODE && (pin_low || !above_inh);
		end
	end

	// power-on values of mode and status bits
	always_ff @(posedge CLK) begin
		if (RST || power_on) begin
			WRITE_ENABLE_LATCH <= 1'h0;
			DEEP_SLEEP <= 1'h0;
		end else begin
			if (WRITE_CMD_SEEN && WRITE_ALLOWED && !DEEP_SLEEP) begin
				WRITE_ENABLE_LATCH <= 1'h1;
			end else if (CYCLE_DONE) begin
				WRITE_ENABLE_LATCH <= 1'h0;
			end
			if (ENTER_DEEP_SLEEP && state == ST_STANDBY) begin
				DEEP_SLEEP <= 1'h1;
			end
		end
	end
	always_ff @(posedge CLK) begin
		if (RST) begin
			CYCLE_ACTIVE_FLAG <= 1'h0;
		end else begin
			CYCLE_ACTIVE_FLAG <= next_state == ST_ARRAY_CYCLE || next_state == ST_STATUS_CYCLE
				|| next_state == ST_STATUS_FINISH;
		end
	end

	// every reset pulse clears the lock bits
	always_ff @(posedge CLK) begin
		if (RST || rst_fall || power_on) begin
			WRITE_LOCK <= RESET_LOCK;
			LOCK_DOWN <= RESET_LOCK;
		end else if (LOCK_SET && WRITE_ALLOWED) begin
			WRITE_LOCK <= 1'h1;
			LOCK_DOWN <= 1'h1;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			ERASED_VALUE <= ERASED_BYTE;
		end else begin
			ERASED_VALUE <= ERASED_BYTE;
		end
	end
endmodule

// ---- hdl/pwr_seq_pkg.sv ----
// Purpose: Constants and types for the flash power and reset sequencer.
// Assumes: 100 MHz system clock.
// Notes: Times are kept in their own unit; cycle counts derive from them.
package pwr_seq_pkg;
	localparam int CLK_MHZ = 100;
	// Least supply-good to select delay, in microseconds.
	localparam int SELECT_AFTER_SUPPLY_US = 30;
	// Write holdoff, least figure, in milliseconds.
	localparam int WRITE_HOLDOFF_MS = 1;
	localparam int SELECT_AFTER_SUPPLY_CYC = SELECT_AFTER_SUPPLY_US * CLK_MHZ;
	localparam int WRITE_HOLDOFF_CYC = WRITE_HOLDOFF_MS * 1000 * CLK_MHZ;
	// Post-reset recovery time in nanoseconds; value not given, plain default.
	localparam int POST_RESET_RECOVERY_NS = 100;
	localparam int POST_RESET_RECOVERY_CYC = (POST_RESET_RECOVERY_NS + 9) / 10;
	// Status write time in microseconds; value not given, plain default.
	localparam int STATUS_WRITE_US = 10;
	localparam int STATUS_WRITE_CYC = STATUS_WRITE_US * CLK_MHZ;
	localparam int CNT_W = 24;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic RESET_LOCK = 1'h0;

	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_STANDBY = 3'h1,
		ST_DECODE = 3'h2,
		ST_ARRAY_CYCLE = 3'h3,
		ST_STATUS_CYCLE = 3'h4,
		ST_RESET_HOLD = 3'h5,
		ST_STATUS_FINISH = 3'h6
	} seq_state_t;
endpackage
